// File: cpem_ctrl.sv
// Host sequencer driving the modulation unit and PLL control registers
`timescale 1ns/1ns
// Functional notes
// R01 - Mode field selects off or three modes
// R02 - Mode 1 only with multiplier field one
// R03 - Mode 2 is the stop path from 3
// R04 - Active modes use programmed strength and tolerance
// R05 - Refuse activation at 50 MHz system clock
// R06 - Mode 1 strength is written as zero
// R07 - Strength and tolerance within strong limits
// R08 - Modes 2,3: tolerance at most (strength+1)/2
// R09 - Mode 2 strength never above 43
// R10 - Mode 3 tolerance plus strength within 43
// R11 - Activate only with PLL running and locked
// R12 - Device resets into mode 0 defaults
// R13 - Start: tol 1, sup 1, mode, sup, tol
// R14 - Stop from 3 via 2, then tol, sup
// R15 - Wait 8 system cycles before polling flag
// R16 - Flag within 80 cycles, then write mode 0
// R17 - Active flag reads one when multiplier nonzero
// R18 - In-phase flag set for phase 0 or 1
// R19 - Lock flag readable in PLL control
// R20 - System clock equals crystal times multiplier plus one
// R21 - Multiplier written only outside PLL mode
module cpem_ctrl (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout_q,
  output logic                            hresp_q,
  output logic [31:0]                     hrdata_q,
  input  wire logic                       pll_mode_on,
  output cpem_pkg::cpem_dev_req_type      dev_req_q,
  input  wire logic [31:0]                dev_rdata
);
  import cpem_pkg::*;

  parameter logic [5:0] STRONG_TOL_MAX = 6'd22;
  parameter logic [5:0] STRONG_SUP_MAX = 6'd43;

  // AHB-Lite slave: writes take no wait state, reads one
  logic        ph_wr_q, ph_rd_q;
  logic [7:0]  ph_addr_q;
  logic [31:0] cfg_q, pll_cfg_q;
  logic        err_q, tmo_q;
  logic [7:0]  pll_stat_q;
  logic        in_phase_flag_seen_q;
  cpem_state_type state_q, state_d;
  logic [1:0]  run_mode_q;
  logic [5:0]  run_tol_q, run_sup_q;
  logic [PMF_W-1:0] run_pmf_q;

  wire ahb_go   = hsel && htrans[1] && hready;
  wire wr_en    = ph_wr_q && hready;
  wire wr_ctrl  = wr_en && (ph_addr_q == OFS_CTRL);
  wire wr_stat  = wr_en && (ph_addr_q == OFS_STATUS);
  wire start_p  = wr_ctrl && hwdata[CTRL_START_BIT];
  wire stop_p   = wr_ctrl && hwdata[CTRL_STOP_BIT];
  wire pllwr_p  = wr_ctrl && hwdata[CTRL_PLLWR_BIT];
  wire busy     = (state_q != S_IDLE) && (state_q != S_RUN);
  wire [31:0] status_word = {3'b000, state_q, 7'h00, in_phase_flag_seen_q, pll_stat_q, 4'h0,
                             tmo_q, err_q, state_q == S_RUN, busy};
  wire [31:0] rd_mux = (ph_addr_q == OFS_CFG)     ? cfg_q :
                       (ph_addr_q == OFS_PLL_CFG) ? pll_cfg_q :
                       (ph_addr_q == OFS_STATUS)  ? status_word : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_q     <= 1'b0;
      ph_rd_q     <= 1'b0;
      ph_addr_q   <= 8'h00;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      hrdata_q    <= 32'h00000000;
    end else begin
      if (ahb_go) begin
        ph_wr_q   <= hwrite;
        ph_rd_q   <= !hwrite;
        ph_addr_q <= haddr[7:0];
        hreadyout_q <= hwrite;
      end else if (hready) begin
        ph_wr_q <= 1'b0;
        ph_rd_q <= 1'b0;
      end
      if (ph_rd_q && !hreadyout_q) begin
        hrdata_q    <= rd_mux;
        hreadyout_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q     <= CFG_RST;
      pll_cfg_q <= PLL_CFG_RST;
    end else if (wr_en) begin
      if (ph_addr_q == OFS_CFG)
        cfg_q <= hwdata & CFG_MASK;
      if (ph_addr_q == OFS_PLL_CFG)
        pll_cfg_q <= hwdata & PLL_CFG_MASK;
    end
  end

  // Configuration screening before any activation
  wire [1:0]       cfg_mode = cfg_q[CFG_MODE_LSB +: 2];
  wire [5:0]       cfg_tol  = cfg_q[CFG_TOL_LSB +: 6];
  wire [5:0]       cfg_sup  = cfg_q[CFG_SUP_LSB +: 6];
  wire [PMF_W-1:0] cfg_pmf  = pll_cfg_q[PLLCFG_MULT_LSB +: PMF_W];
  wire [7:0]       cfg_xtal = pll_cfg_q[PLLCFG_XTAL_LSB +: 8];
  wire [12:0] system_clock_freq_mhz = ({9'h000, cfg_pmf} + 13'd1) * {5'h00, cfg_xtal};   // [R20]
  wire [6:0]  tol2     = {cfg_tol, 1'b0};
  wire [6:0]  sup_p1   = {1'b0, cfg_sup} + 7'd1;
  wire [6:0]  par_sum  = {1'b0, cfg_tol} + {1'b0, cfg_sup};
  wire lim_ok  = (cfg_tol <= STRONG_TOL_MAX) && (cfg_sup <= STRONG_SUP_MAX);   // [R07]
  wire m1_ok   = (cfg_sup == PAR_ZERO) && (cfg_pmf == PMF_MODE1);              // [R02] [R06]
  wire m23_ok  = (tol2 <= sup_p1) && (cfg_sup != PAR_ZERO)                     // [R08]
              && ((cfg_mode == MODE_2) ? ({1'b0, cfg_sup} <= SUP_M2_MAX)       // [R09]
                                       : (par_sum <= SUM_M3_MAX));             // [R10]
  wire cfg_ok  = (cfg_mode != MODE_OFF) && lim_ok && (system_clock_freq_mhz < SYSTEM_CLOCK_FREQ_OFF_MHZ) // [R01] [R05]
              && ((cfg_mode == MODE_1) ? m1_ok : m23_ok);
  wire pll_ok  = pll_mode_on && dev_rdata[PLL_ACT_BIT] && dev_rdata[PLL_LCK_BIT]; // [R11] [R17] [R19]
  wire in_phase_flag_rd = dev_rdata[7];   // [R18]
  wire [1:0] dn_mode  = (run_mode_q == MODE_3) ? MODE_2 : run_mode_q;   // [R03]
  wire [5:0] sup_init = (run_mode_q == MODE_1) ? PAR_ZERO : PAR_ONE;

  // Settle wait and in-phase timeout
  logic tmr_done;
  wire  tmr_load = (state_d == S_D_SETTLE && state_q != S_D_SETTLE)
                || (state_d == S_D_RD && state_q == S_D_SETTLE);
  wire [CNT_W-1:0] tmr_val = (state_q == S_D_SETTLE) ? CNT_W'(IN_PHASE_FLAG_CYC) : CNT_W'(SETTLE_CYC);

  cpem_wait_timer #(.CNT_W(CNT_W)) u_timer (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (start_p && cfg_ok)
          state_d = S_CHK_RD;
        else if (pllwr_p && !pll_mode_on)   // [R21]
          state_d = S_PLL_WR;
      end
      S_PLL_WR:   state_d = S_IDLE;
      S_CHK_RD:   state_d = pll_ok ? S_I_TOL : S_IDLE;   // [R11]
      S_CHK_EV:   state_d = S_IDLE;
      S_I_TOL:    state_d = (run_mode_q == MODE_1) ? S_I_MODE : S_I_SUP;   // [R13]
      S_I_SUP:    state_d = S_I_MODE;
      S_I_MODE:   state_d = S_I_FSUP;
      S_I_FSUP:   state_d = S_I_FTOL;
      S_I_FTOL:   state_d = S_RUN;
      S_RUN: begin
        if (stop_p)
          state_d = (run_mode_q == MODE_3) ? S_D_M2 : S_D_TOL;   // [R14]
      end
      S_D_M2:     state_d = S_D_TOL;
      S_D_TOL:    state_d = (run_mode_q == MODE_1) ? S_D_SETTLE : S_D_SUP;
      S_D_SUP:    state_d = S_D_SETTLE;
      S_D_SETTLE: state_d = tmr_done ? S_D_RD : S_D_SETTLE;   // [R15]
      S_D_RD:     state_d = in_phase_flag_rd ? S_D_OFF : S_D_EV;       // [R16]
      S_D_EV:     state_d = S_D_RD;
      S_D_OFF:    state_d = S_IDLE;
      default:    state_d = S_IDLE;
    endcase
  end

  // Device access issued for the state being entered
  cpem_dev_req_type dev_req_d;
  always_comb begin
    dev_req_d = '0;
    dev_req_d.sel = DEV_SEL_MOD;
    case (state_d)
      S_PLL_WR: begin
        dev_req_d.wr    = 1'b1;
        dev_req_d.sel   = DEV_SEL_PLL;
        dev_req_d.wdata = {24'h000000, 4'h0, cfg_pmf};
      end
      S_CHK_RD: begin
        dev_req_d.rd  = 1'b1;
        dev_req_d.sel = DEV_SEL_PLL;
      end
      S_I_TOL:  begin dev_req_d.wr = 1'b1; dev_req_d.wdata = cpem_mk_word(MODE_OFF, PAR_ONE, PAR_ZERO); end
      S_I_SUP:  begin dev_req_d.wr = 1'b1; dev_req_d.wdata = cpem_mk_word(MODE_OFF, PAR_ONE, PAR_ONE); end
      S_I_MODE: begin dev_req_d.wr = 1'b1; dev_req_d.wdata = cpem_mk_word(run_mode_q, PAR_ONE, sup_init); end
      S_I_FSUP: begin dev_req_d.wr = 1'b1; dev_req_d.wdata = cpem_mk_word(run_mode_q, PAR_ONE, run_sup_q); end
      S_I_FTOL: begin dev_req_d.wr = 1'b1; dev_req_d.wdata = cpem_mk_word(run_mode_q, run_tol_q, run_sup_q); end   // [R04]
      S_D_M2:   begin dev_req_d.wr = 1'b1; dev_req_d.wdata = cpem_mk_word(MODE_2, run_tol_q, run_sup_q); end
      S_D_TOL:  begin dev_req_d.wr = 1'b1; dev_req_d.wdata = cpem_mk_word(dn_mode, PAR_ONE, run_sup_q); end
      S_D_SUP:  begin dev_req_d.wr = 1'b1; dev_req_d.wdata = cpem_mk_word(dn_mode, PAR_ONE, PAR_ONE); end
      S_D_RD:   dev_req_d.rd = 1'b1;
      S_D_OFF:  begin dev_req_d.wr = 1'b1; dev_req_d.wdata = cpem_mk_word(MODE_OFF, PAR_ONE, sup_init); end
      default:  dev_req_d = dev_req_d;
    endcase
  end

  wire err_set = (start_p && !(state_q == S_IDLE && cfg_ok)) || (state_q == S_CHK_RD && !pll_ok)
              || (pllwr_p && !(state_q == S_IDLE && !pll_mode_on && !start_p))
              || (stop_p && state_q != S_RUN);
  wire tmo_set = (state_q == S_D_RD) && !in_phase_flag_rd && tmr_done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q     <= S_IDLE;
      dev_req_q   <= '0;
      run_mode_q  <= MODE_OFF;
      run_tol_q   <= PAR_ZERO;
      run_sup_q   <= PAR_ZERO;
      run_pmf_q   <= '0;
      pll_stat_q  <= 8'h00;
      in_phase_flag_seen_q <= 1'b0;
      err_q       <= 1'b0;
      tmo_q       <= 1'b0;
    end else begin
      state_q   <= state_d;
      dev_req_q <= dev_req_d;
      if (state_q == S_IDLE && state_d == S_CHK_RD) begin
        run_mode_q <= cfg_mode;
        run_tol_q  <= cfg_tol;
        run_sup_q  <= cfg_sup;
        run_pmf_q  <= cfg_pmf;
      end
      if (state_q == S_CHK_RD)
        pll_stat_q <= dev_rdata[7:0];
      if (state_q == S_D_RD)
        in_phase_flag_seen_q <= in_phase_flag_rd;
      // Set wins over a clear in the same cycle
      err_q <= err_set || (err_q && !(wr_stat && hwdata[ST_ERR_BIT]));
      tmo_q <= tmo_set || (tmo_q && !(wr_stat && hwdata[ST_TMO_BIT]));
    end
  end

  // Observation helpers for the checks below
  cpem_mod_word_type aw;
  logic [1:0]  last_mode_q;
  logic [5:0]  last_tol_q;
  logic [CNT_W-1:0] since_wr_q;
  assign aw = cpem_mod_word_type'(dev_req_q.wdata);
  wire mod_wr = dev_req_q.wr && (dev_req_q.sel == DEV_SEL_MOD);
  wire mod_rd = dev_req_q.rd && (dev_req_q.sel == DEV_SEL_MOD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_mode_q <= MODE_OFF;   // [R12]
      last_tol_q  <= PAR_ZERO;
      since_wr_q  <= '0;
    end else if (mod_wr) begin
      last_mode_q <= aw.mode;
      last_tol_q  <= aw.clock_tolerance;
      since_wr_q  <= '0;
    end else if (since_wr_q != CNT_W'(SETTLE_CYC)) begin
      since_wr_q <= since_wr_q + 1'b1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_M1_SUP_ZERO: assert property (mod_wr && aw.mode == MODE_1 |-> aw.suppression_strength == PAR_ZERO) // [R06]
    else $error("mode 1 written with nonzero strength");
  AST_M1_PMF: assert property ($rose(state_q == S_I_MODE) && run_mode_q == MODE_1 |-> run_pmf_q == PMF_MODE1) // [R02]
    else $error("mode 1 started with wrong multiplier");
  AST_STRONG: assert property (mod_wr && aw.mode != MODE_OFF |-> aw.clock_tolerance <= STRONG_TOL_MAX && aw.suppression_strength <= STRONG_SUP_MAX) // [R07]
    else $error("parameter above strong limit");
  AST_TOL_HALF: assert property (mod_wr && aw.mode >= MODE_2 |-> {aw.clock_tolerance, 1'b0} <= {1'b0, aw.suppression_strength} + 7'd1) // [R08]
    else $error("tolerance above half strength plus one");
  AST_M2_SUP: assert property (mod_wr && aw.mode == MODE_2 |-> {1'b0, aw.suppression_strength} <= SUP_M2_MAX) // [R09]
    else $error("mode 2 strength above limit");
  AST_M3_SUM: assert property (mod_wr && aw.mode == MODE_3 |-> {1'b0, aw.clock_tolerance} + {1'b0, aw.suppression_strength} <= SUM_M3_MAX) // [R10]
    else $error("mode 3 sum above limit");
  AST_PLL_FIRST: assert property (mod_wr && aw.mode != MODE_OFF && last_mode_q == MODE_OFF |-> pll_stat_q[PLL_ACT_BIT] && pll_stat_q[PLL_LCK_BIT]) // [R11]
    else $error("activation without running locked PLL");
  AST_INIT_ORDER: assert property (mod_wr && aw.mode != MODE_OFF && last_mode_q == MODE_OFF |-> last_tol_q == PAR_ONE && aw.clock_tolerance == PAR_ONE ##1 mod_wr ##1 mod_wr) // [R13]
    else $error("activation order broken");
  AST_STOP_VIA_M2: assert property (mod_wr && last_mode_q == MODE_3 && aw.mode != MODE_3 |-> aw.mode == MODE_2 && aw.clock_tolerance == last_tol_q) // [R14]
    else $error("mode 3 left without mode 2 step");
  AST_SETTLE: assert property (mod_rd |-> since_wr_q == CNT_W'(SETTLE_CYC) && $past(state_q, 1) != S_D_SUP) // [R15]
    else $error("in-phase flag polled too early");
  AST_OFF_IN_PHASE_FLAG: assert property (mod_wr && aw.mode == MODE_OFF && last_mode_q != MODE_OFF |-> in_phase_flag_seen_q && $past(mod_rd, 1)) // [R16]
    else $error("mode 0 written before in-phase flag");
  AST_PMF_WR: assert property (dev_req_q.wr && dev_req_q.sel == DEV_SEL_PLL |-> !$past(pll_mode_on, 1) && last_mode_q == MODE_OFF) // [R21]
    else $error("multiplier written in PLL mode");
  AST_RD_WAIT: assert property (ahb_go && !hwrite |=> !hreadyout_q ##1 hreadyout_q)
    else $error("read answer timing wrong");

  COV_RUN:     cover property ($rose(state_q == S_RUN) && run_mode_q == MODE_3);
  COV_STOP:    cover property (state_q == S_D_OFF ##1 state_q == S_IDLE);
  COV_TIMEOUT: cover property ($rose(tmo_q));
  COV_REFUSE:  cover property ($rose(err_q));
endmodule

// File: cpem_pkg.sv
// Package with constants, types and helpers of the clock-phase modulation host controller
package cpem_pkg;

  // Own AHB-Lite register map (byte offsets)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CFG     = 8'h04;
  localparam logic [7:0] OFS_PLL_CFG = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;

  // Control bits (write one to issue)
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_STOP_BIT   = 1;
  localparam int CTRL_PLLWR_BIT  = 2;
  // Configuration fields
  localparam int CFG_MODE_LSB    = 0;
  localparam int CFG_TOL_LSB     = 8;
  localparam int CFG_SUP_LSB     = 16;
  localparam int PLLCFG_MULT_LSB = 0;
  localparam int PLLCFG_XTAL_LSB = 8;
  localparam logic [31:0] CFG_MASK     = 32'h003F3F03;
  localparam logic [31:0] PLL_CFG_MASK = 32'h0000FF0F;
  localparam logic [31:0] CFG_RST      = 32'h00000000;
  localparam logic [31:0] PLL_CFG_RST  = 32'h00000000;
  // Status fields
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_RUN_BIT   = 1;
  localparam int ST_ERR_BIT   = 2;
  localparam int ST_TMO_BIT   = 3;
  localparam int ST_PLL_LSB   = 8;
  localparam int ST_IN_PHASE_FLAG_BIT  = 16;
  localparam int ST_STATE_LSB = 24;

  // Device pll_control layout
  localparam int PLL_ACT_BIT = 7;
  localparam int PLL_LCK_BIT = 6;
  localparam int PMF_W       = 4;
  localparam logic DEV_SEL_MOD = 1'b0;
  localparam logic DEV_SEL_PLL = 1'b1;

  // Modulation modes and limits
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_1   = 2'h1;
  localparam logic [1:0] MODE_2   = 2'h2;
  localparam logic [1:0] MODE_3   = 2'h3;
  localparam logic [5:0] PAR_ONE  = 6'h01;
  localparam logic [5:0] PAR_ZERO = 6'h00;
  localparam logic [PMF_W-1:0] PMF_MODE1 = 4'h1;
  localparam logic [6:0] SUP_M2_MAX  = 7'd43;
  localparam logic [6:0] SUM_M3_MAX  = 7'd43;
  localparam logic [12:0] SYSTEM_CLOCK_FREQ_OFF_MHZ = 13'd50;

  // Timing: system clock cycles converted at the slowest system clock
  localparam int HCLK_MHZ     = 100;
  localparam int SYS_MIN_MHZ  = 8;
  localparam int SETTLE_SYS   = 8;
  localparam int IN_PHASE_FLAG_SYS     = 80;
  localparam int SETTLE_CYC   = (SETTLE_SYS * HCLK_MHZ + SYS_MIN_MHZ - 1) / SYS_MIN_MHZ;
  localparam int IN_PHASE_FLAG_CYC     = (IN_PHASE_FLAG_SYS * HCLK_MHZ) / SYS_MIN_MHZ;
  localparam int CNT_W        = 11;

  typedef enum logic [4:0] {
    S_IDLE     = 5'h00,
    S_PLL_WR   = 5'h01,
    S_CHK_RD   = 5'h02,
    S_CHK_EV   = 5'h03,
    S_I_TOL    = 5'h04,
    S_I_SUP    = 5'h05,
    S_I_MODE   = 5'h06,
    S_I_FSUP   = 5'h07,
    S_I_FTOL   = 5'h08,
    S_RUN      = 5'h09,
    S_D_M2     = 5'h0A,
    S_D_TOL    = 5'h0B,
    S_D_SUP    = 5'h0C,
    S_D_SETTLE = 5'h0D,
    S_D_RD     = 5'h0E,
    S_D_EV     = 5'h0F,
    S_D_OFF    = 5'h10
  } cpem_state_type;

  typedef struct packed {
    logic [7:0] test_sel;
    logic [7:0] rsvd_hi;
    logic [1:0] mode;
    logic [5:0] clock_tolerance;
    logic       in_phase_flag;
    logic       rsvd_lo;
    logic [5:0] suppression_strength;
  } cpem_mod_word_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        sel;
    logic [31:0] wdata;
  } cpem_dev_req_type;

  function automatic logic [31:0] cpem_mk_word(logic [1:0] m, logic [5:0] t, logic [5:0] s);
    cpem_mod_word_type w;
    w = '0;
    w.mode = m;
    w.clock_tolerance = t;
    w.suppression_strength = s;
    return w;
  endfunction

endpackage

// File: cpem_wait_timer.sv
// Down counter used for the settle wait and the in-phase timeout
`timescale 1ns/1ns
module cpem_wait_timer #(
  parameter int CNT_W = 11
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  done
);
  logic [CNT_W-1:0] count_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_val;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  // Done must not look at load: load is decoded from the next state
  assign done = (count_q == '0);
endmodule

// File: cpem_dev_model.sv
// Behavioural model of the modulation unit and its PLL control register
`timescale 1ns/1ns
module cpem_dev_model
  import cpem_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire cpem_pkg::cpem_dev_req_type dev_req,
  input  wire logic                  lock_ok,
  input  wire logic                  slow,
  output logic [31:0]                dev_rdata
);
  import cpem_pkg::*;
  logic [1:0] mode_q;
  logic [5:0] tol_q;
  logic [5:0] sup_q;
  logic [3:0] mult_q;
  logic [6:0] phase_q;
  logic [5:0] flip_q;
  // Strength ignored in mode 1
  wire        spread   = (tol_q > 6'h01) || (sup_q > 6'h01 && mode_q != MODE_1);
  wire        in_phase_flag     = (phase_q <= 7'h01);
  wire        act      = (mult_q != 4'h0);
  wire [31:0] mod_word = {16'h0000, mode_q, tol_q, in_phase_flag, 1'h0, sup_q};
  wire [31:0] pll_word = {24'h000000, act, lock_ok, 2'h0, mult_q};
  // Bus not read: a toggling pattern, never the last value
  wire [31:0] idle_val = {26'h0000000, flip_q} ^ 32'hA5A5A5A5;
  assign dev_rdata = !dev_req.rd ? idle_val : (dev_req.sel ? pll_word : mod_word);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q  <= MODE_OFF;
      tol_q   <= 6'h00;
      sup_q   <= 6'h00;
      mult_q  <= 4'h0;
      phase_q <= 7'h00;
      flip_q  <= 6'h00;
    end else begin
      flip_q <= flip_q + 6'h01;
      if (dev_req.wr && dev_req.sel) begin
        mult_q <= dev_req.wdata[3:0];
      end
      if (dev_req.wr && !dev_req.sel) begin
        mode_q <= dev_req.wdata[15:14];
        tol_q  <= dev_req.wdata[13:8];
        sup_q  <= dev_req.wdata[5:0];
      end
      // Slow return still inside the 80 cycle limit
      if (mode_q == MODE_OFF) begin
        phase_q <= 7'h00;
      end else if (spread) begin
        phase_q <= slow ? 7'h4E : 7'h03;
      end else if (phase_q != 7'h00) begin
        phase_q <= phase_q - 7'h01;
      end
    end
  end
endmodule

// File: clock_phase_emi_modulator_tb_top.sv
// Self-checking bench for the clock-phase modulation host controller
`timescale 1ns/1ns
module clock_phase_emi_modulator_tb_top;
  import cpem_pkg::*;
  logic             hclk = 1'h0;
  logic             hresetn = 1'h0;
  logic             hsel = 1'h0;
  logic [31:0]      haddr = 32'h0;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'h0;
  logic [2:0]       hsize = 3'h2;
  logic [31:0]      hwdata = 32'h0;
  logic             pll_mode_on = 1'h0;
  logic             lock_ok = 1'h1;
  logic             slow = 1'h0;
  wire              hreadyout_q;
  wire              hresp_q;
  wire [31:0]       hrdata_q;
  wire [31:0]       dev_rdata;
  cpem_dev_req_type dev_req_q;
  int               miscompares = 0;
  int               checks_done = 0;
  int               cyc = 0;
  int               last_wr_cyc = 0;
  int               min_gap = 9999;
  logic [32:0]      wlog[$];

  always #5 hclk = ~hclk;

  cpem_ctrl cpem_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout_q),
    .hreadyout_q(hreadyout_q), .hresp_q(hresp_q), .hrdata_q(hrdata_q),
    .pll_mode_on(pll_mode_on), .dev_req_q(dev_req_q), .dev_rdata(dev_rdata));
  cpem_dev_model cpem_dev_model_inst (.hclk(hclk), .hresetn(hresetn), .dev_req(dev_req_q),
    .lock_ok(lock_ok), .slow(slow), .dev_rdata(dev_rdata));

  // Log device writes; track gap from last write to a mode-word poll
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (dev_req_q.wr === 1'h1) begin
      wlog.push_back({dev_req_q.sel, dev_req_q.wdata});
      last_wr_cyc <= cyc;
    end
    if (dev_req_q.rd === 1'h1 && dev_req_q.sel === DEV_SEL_MOD && cyc - last_wr_cyc < min_gap) begin
      min_gap <= cyc - last_wr_cyc;
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Hready and read data are taken as sampled at the rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic r;
    int   n;
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      r = hreadyout_q;
      n++;
    end while (r !== 1'h1 && n < 50);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge hclk);
      r = hreadyout_q;
      rd = hrdata_q;
      n++;
    end while (r !== 1'h1 && n < 50);
    if (r !== 1'h1) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'h1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'h0, a, 32'h0, d);
  endtask

  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] st;
    int          n;
    n = 0;
    do begin
      rd(OFS_STATUS, st);
      n++;
    end while ((st & m) !== v && n < 200);
    if ((st & m) !== v) begin
      miscompares++;
      $display("MISMATCH at %0t: status %h expected %h", $time, st & m, v);
      summarize();
    end
  endtask

  function automatic logic [31:0] mw(input logic [1:0] m, input logic [5:0] t,
                                     input logic [5:0] s);
    return {16'h0000, m, t, 2'h0, s};
  endfunction

  task automatic nw(input logic s, input logic [31:0] e);
    logic [32:0] g;
    g = (wlog.size() > 0) ? wlog.pop_front() : 33'hX;
    chk(g, {s, e});
  endtask

  task automatic t_reset;
    logic [31:0] d;
    rd(OFS_CFG, d);
    chk({1'h0, d}, {1'h0, CFG_RST});
    rd(OFS_STATUS, d);
    chk({1'h0, d & 32'h1F000003}, 33'h0);
    chk({32'h00000000, hresp_q}, 33'h0);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, d);
    chk({1'h0, d}, 33'h0);
    $display("test reset done");
  endtask

  task automatic t_pll;
    wr(OFS_PLL_CFG, 32'h00000801);
    wr(OFS_CTRL, 32'h00000004);
    wait_st(32'h00000001, 32'h00000000);
    nw(DEV_SEL_PLL, 32'h00000001);
    pll_mode_on <= 1'h1;
    wr(OFS_CTRL, 32'h00000004);
    wait_st(32'h00000004, 32'h00000004);
    chk(33'(wlog.size()), 33'h0);
    wr(OFS_STATUS, 32'h00000004);
    $display("test multiplier done");
  endtask

  task automatic t_refuse(input logic [31:0] cfg, input logic [31:0] pll, input logic pmo,
                          input logic lk);
    logic [31:0] st;
    pll_mode_on <= pmo;
    lock_ok <= lk;
    wr(OFS_PLL_CFG, pll);
    wr(OFS_CFG, cfg);
    wr(OFS_CTRL, 32'h00000001);
    wait_st(32'h00000007, 32'h00000004);
    chk(33'(wlog.size()), 33'h0);
    wr(OFS_STATUS, 32'h00000004);
    rd(OFS_STATUS, st);
    chk({1'h0, st & 32'h00000007}, 33'h0);
    $display("test refusal done");
  endtask

  task automatic t_start(input logic [1:0] m, input logic [5:0] t, input logic [5:0] s);
    logic [31:0] st;
    logic [5:0]  s1;
    s1 = (m == MODE_1) ? PAR_ZERO : PAR_ONE;
    wr(OFS_CFG, {10'h000, s, 2'h0, t, 6'h00, m});
    wr(OFS_CTRL, 32'h00000001);
    wait_st(32'h00000002, 32'h00000002);
    nw(DEV_SEL_MOD, mw(MODE_OFF, PAR_ONE, PAR_ZERO));
    if (m != MODE_1) nw(DEV_SEL_MOD, mw(MODE_OFF, PAR_ONE, PAR_ONE));
    nw(DEV_SEL_MOD, mw(m, PAR_ONE, s1));
    nw(DEV_SEL_MOD, mw(m, PAR_ONE, s));
    nw(DEV_SEL_MOD, mw(m, t, s));
    chk(33'(wlog.size()), 33'h0);
    rd(OFS_STATUS, st);
    chk({1'h0, st & 32'h0000C002}, {1'h0, 32'h0000C002});
    $display("test start done");
  endtask

  task automatic t_stop(input logic [1:0] m, input logic [5:0] t, input logic [5:0] s);
    logic [31:0] st;
    logic [1:0]  dm;
    logic [5:0]  sl;
    dm = (m == MODE_3) ? MODE_2 : m;
    sl = (m == MODE_1) ? PAR_ZERO : PAR_ONE;
    wr(OFS_CTRL, 32'h00000002);
    wait_st(32'h00000003, 32'h00000000);
    if (m == MODE_3) nw(DEV_SEL_MOD, mw(MODE_2, t, s));
    nw(DEV_SEL_MOD, mw(dm, PAR_ONE, s));
    if (m != MODE_1) nw(DEV_SEL_MOD, mw(dm, PAR_ONE, PAR_ONE));
    nw(DEV_SEL_MOD, mw(MODE_OFF, PAR_ONE, sl));
    rd(OFS_STATUS, st);
    chk({1'h0, st & 32'h00010008}, {1'h0, 32'h00010000});
    chk(33'(min_gap >= SETTLE_CYC), 33'h1);
    $display("test stop done");
  endtask

  initial begin
    #900000;
    miscompares++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset();
    t_pll();
    t_refuse(32'h00000000, 32'h00000801, 1'h1, 1'h1);
    t_refuse(32'h00010101, 32'h00000801, 1'h1, 1'h1);
    t_refuse(32'h00000701, 32'h00000803, 1'h1, 1'h1);
    t_refuse(32'h00001701, 32'h00000801, 1'h1, 1'h1);
    t_refuse(32'h00040302, 32'h00000801, 1'h1, 1'h1);
    t_refuse(32'h002C0102, 32'h00000801, 1'h1, 1'h1);
    t_refuse(32'h002A0203, 32'h00000801, 1'h1, 1'h1);
    t_refuse(32'h00140A03, 32'h00001901, 1'h1, 1'h1);
    t_refuse(32'h00140A03, 32'h00000801, 1'h0, 1'h1);
    t_refuse(32'h00140A03, 32'h00000801, 1'h1, 1'h0);
    lock_ok <= 1'h1;
    wr(OFS_PLL_CFG, 32'h00000801);
    slow <= 1'h1;
    t_start(MODE_3, 6'h0A, 6'h14);
    t_stop(MODE_3, 6'h0A, 6'h14);
    t_start(MODE_1, 6'h07, 6'h00);
    t_stop(MODE_1, 6'h07, 6'h00);
    slow <= 1'h0;
    t_start(MODE_2, 6'h05, 6'h2B);
    t_stop(MODE_2, 6'h05, 6'h2B);
    summarize();
  end
endmodule
